// *** rtl/eeprom_consts.vh ***
// Constants shared by the two-wire EEPROM target write path
`ifndef EEPROM_CONSTS_VH
`define EEPROM_CONSTS_VH

// Clock rate and self-timed write cycle
`define CLK_MHZ        125
`define T_WR_US        5000
`define WR_CNT_W       20

// Word framing
`define ACK_BIT        4'h8
`define BIT_ONE        4'h1

// Device address field values
`define DEV_MEM        4'hA
`define DEV_SPC        4'hB

// Word address field positions
`define WA_LOCK_BIT    6
`define WA_AREA_HI     7
`define WA_AREA_LO     6
`define WA_SEC_CODE    2'h0
`define LOCK_DATA_BIT  1

// Receive states
`define ST_IDLE        3'h0
`define ST_DEV         3'h1
`define ST_WADDR       3'h2
`define ST_DATA        3'h3
`define ST_READ        3'h4
`define ST_SKIP        3'h5

// Access areas
`define AR_MEM         2'h0
`define AR_SEC         2'h1
`define AR_LOCK        2'h2
`define AR_UID         2'h3

// Page and memory sizes
`define PAGE_LAST      4'hF
`define MEM_AW         11
`define MEM_WORDS      2048

`endif

// *** rtl/pin_sync.v ***
// Pin synchroniser and start, stop and clock edge detection
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_consts.vh"

module pin_sync (
    // Clock and reset
    input  wire       clock_i,
    input  wire       nrst_i,
    // Raw pins
    input  wire       scl_i,
    input  wire       sda_i,
    input  wire       wp_i,
    // Synchronised levels
    output wire       scl_o,
    output wire       sda_o,
    output wire       wp_o,
    // Events, one cycle each
    output wire       scl_rise_o,
    output wire       scl_fall_o,
    output wire       start_o,
    output wire       stop_o
);

    reg  [2:0] meta_q;
    reg  [2:0] sync_q;
    reg  [1:0] last_q;

    // Two flops per pin, then one more stage of scl and sda for edges
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            meta_q <= 3'h3;
            sync_q <= 3'h3;
            last_q <= 2'h3;
        end else begin
            meta_q <= {wp_i, sda_i, scl_i};
            sync_q <= meta_q;
            last_q <= sync_q[1:0];
        end
    end

    assign scl_o      = sync_q[0];
    assign sda_o      = sync_q[1];
    assign wp_o       = sync_q[2];
    assign scl_rise_o = sync_q[0] & ~last_q[0];
    assign scl_fall_o = ~sync_q[0] & last_q[0];
    // Data moving while the clock stays high marks start or stop
    assign start_o    = sync_q[0] & last_q[0] & last_q[1] & ~sync_q[1];
    assign stop_o     = sync_q[0] & last_q[0] & ~last_q[1] & sync_q[1];

endmodule
`default_nettype wire

// *** rtl/byte_store.v ***
// Data memory of 2048 bytes with one write port and one read port
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_consts.vh"

module byte_store (
    // Clock and reset
    input  wire                   clock_i,
    input  wire                   nrst_i,
    // Write port
    input  wire                   we_i,
    input  wire [`MEM_AW-1:0]     waddr_i,
    input  wire [7:0]             wdata_i,
    // Read port, one cycle latency
    input  wire [`MEM_AW-1:0]     raddr_i,
    output reg  [7:0]             rdata_o
);

    reg  [7:0] mem_q [0:`MEM_WORDS-1];

    // Array cells hold no reset, like the nonvolatile cells they model
    always @(posedge clock_i) begin
        if (we_i) begin
            mem_q[waddr_i] <= wdata_i;
        end
    end

    // Registered read
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rdata_o <= 8'h00;
        end else begin
            rdata_o <= mem_q[raddr_i];
        end
    end

endmodule
`default_nettype wire

// *** rtl/eeprom_target.v ***
// Two-wire EEPROM target: addressing, page writes, sector lock, write cycle
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_consts.vh"

module eeprom_target #(
    parameter WR_CYCLES = `T_WR_US * `CLK_MHZ
) (
    // Clock and reset
    input  wire                 clock_i,
    input  wire                 nrst_i,
    // Two-wire pins
    input  wire                 scl_i,
    input  wire                 sda_i,
    output reg                  sda_o,
    output reg                  sda_oe_o,
    // Write-protect pin
    input  wire                 wp_i,
    // Status
    output reg                  busy_o,
    output reg                  standby_o,
    output reg                  locked_o,
    // Content inspection, bit 11 selects the sector
    input  wire [`MEM_AW:0]     peek_addr_i,
    output reg  [7:0]           peek_data_o
);

    localparam [`WR_CNT_W-1:0] WR_LOAD = WR_CYCLES[`WR_CNT_W-1:0];

    // ------------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------------
    wire        scl_s;
    wire        sda_s;
    wire        wp_s;
    wire        scl_rise;
    wire        scl_fall;
    wire        start_p;
    wire        stop_p;

    pin_sync u_sync (
        .clock_i    (clock_i),
        .nrst_i     (nrst_i),
        .scl_i      (scl_i),
        .sda_i      (sda_i),
        .wp_i       (wp_i),
        .scl_o      (scl_s),
        .sda_o      (sda_s),
        .wp_o       (wp_s),
        .scl_rise_o (scl_rise),
        .scl_fall_o (scl_fall),
        .start_o    (start_p),
        .stop_o     (stop_p)
    );

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    reg  [2:0]              state_q;
    reg  [3:0]              bit_q;
    reg                     ackph_q;
    reg  [7:0]              shift_q;
    reg  [1:0]              area_q;
    reg  [2:0]              page_q;
    reg  [7:0]              waddr_q;
    reg  [15:0]             mask_q;
    reg                     wpend_q;
    reg                     lockpend_q;
    reg                     busy_q;
    reg  [`WR_CNT_W-1:0]    cnt_q;
    reg                     commit_q;
    reg  [3:0]              cidx_q;
    reg                     lock_q;
    reg  [7:0]              buf_q [0:15];
    reg  [7:0]              sec_q [0:15];
    reg                     byte_ok;

    wire       rx_state = (state_q == `ST_DEV) || (state_q == `ST_WADDR) ||
                          (state_q == `ST_DATA);
    wire       do_shift = scl_rise && rx_state && !ackph_q &&
                          (bit_q != `ACK_BIT);
    wire       decide   = scl_fall && rx_state && !ackph_q &&
                          (bit_q == `ACK_BIT);
    wire       dev_mem  = (shift_q[7:4] == `DEV_MEM);
    wire       dev_hit  = dev_mem || (shift_q[7:4] == `DEV_SPC);
    wire [1:0] wa_area  = shift_q[`WA_AREA_HI:`WA_AREA_LO];
    wire       buf_we   = decide && (state_q == `ST_DATA) && byte_ok;

    // Whether the word just received is acknowledged
    always @* begin
        case (state_q)
            `ST_DEV:   byte_ok = dev_hit;
            `ST_WADDR: byte_ok = 1'b1;
            `ST_DATA: begin
                case (area_q)
                    `AR_MEM:  byte_ok = 1'b1;
                    `AR_SEC:  byte_ok = !lock_q;
                    `AR_LOCK: byte_ok = !lock_q;
                    default:  byte_ok = 1'b0;
                endcase
            end
            default:   byte_ok = 1'b0;
        endcase
    end

    // ------------------------------------------------------------------
    // Receive state machine
    // ------------------------------------------------------------------
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_q    <= `ST_IDLE;
            bit_q      <= 4'h0;
            ackph_q    <= 1'b0;
            shift_q    <= 8'h00;
            area_q     <= `AR_MEM;
            page_q     <= 3'h0;
            waddr_q    <= 8'h00;
            mask_q     <= 16'h0000;
            wpend_q    <= 1'b0;
            lockpend_q <= 1'b0;
            sda_o      <= 1'b0;
            sda_oe_o   <= 1'b0;
            standby_o  <= 1'b1;
        end else if (busy_q) begin
            // Bus ignored while the write cycle runs
            state_q    <= `ST_IDLE;
            sda_oe_o   <= 1'b0;
            ackph_q    <= 1'b0;
            bit_q      <= 4'h0;
            wpend_q    <= 1'b0;
            lockpend_q <= 1'b0;
            // Standby once the write cycle finishes
            if (cnt_q == {{(`WR_CNT_W-1){1'b0}}, 1'b1}) begin
                standby_o <= 1'b1;
            end
        end else if (start_p) begin
            // New command; a truncated one is dropped
            state_q    <= `ST_DEV;
            bit_q      <= 4'h0;
            ackph_q    <= 1'b0;
            sda_oe_o   <= 1'b0;
            mask_q     <= 16'h0000;
            wpend_q    <= 1'b0;
            lockpend_q <= 1'b0;
            standby_o  <= 1'b0;
        end else if (stop_p) begin
            // Pending write goes to the timed cycle, else standby
            state_q    <= `ST_IDLE;
            bit_q      <= 4'h0;
            ackph_q    <= 1'b0;
            sda_oe_o   <= 1'b0;
            standby_o  <= !wpend_q;
        end else if (do_shift) begin
            // Sample on rising clock, most significant bit first
            shift_q <= {shift_q[6:0], sda_s};
            bit_q   <= bit_q + `BIT_ONE;
        end else if (decide) begin
            // Falling edge after the eighth bit: drive the ack
            sda_oe_o <= byte_ok;
            ackph_q  <= 1'b1;
            case (state_q)
                `ST_DEV: begin
                    page_q <= shift_q[3:1];
                    area_q <= dev_mem ? `AR_MEM : `AR_SEC;
                    if (!dev_hit) begin
                        state_q   <= `ST_IDLE;
                        standby_o <= 1'b1;
                    end else if (shift_q[0]) begin
                        state_q <= `ST_READ;
                    end else begin
                        state_q <= `ST_WADDR;
                    end
                end
                `ST_WADDR: begin
                    waddr_q <= shift_q;
                    mask_q  <= 16'h0000;
                    state_q <= `ST_DATA;
                    if (area_q != `AR_MEM) begin
                        if (shift_q[`WA_LOCK_BIT]) begin
                            area_q <= `AR_LOCK;
                        end else if (wa_area == `WA_SEC_CODE) begin
                            area_q <= `AR_SEC;
                        end else begin
                            area_q <= `AR_UID;
                        end
                    end
                end
                `ST_DATA: begin
                    if (!byte_ok) begin
                        state_q <= `ST_SKIP;
                    end else begin
                        // Wrap within the page
                        waddr_q[3:0] <= waddr_q[3:0] + `BIT_ONE;
                        mask_q <= mask_q | (16'h0001 << waddr_q[3:0]);
                        if (area_q == `AR_LOCK) begin
                            if (shift_q[`LOCK_DATA_BIT]) begin
                                lockpend_q <= 1'b1;
                                wpend_q    <= 1'b1;
                            end
                        end else if (area_q == `AR_SEC || !wp_s) begin
                            wpend_q <= 1'b1;
                        end
                    end
                end
                default: begin
                    state_q <= `ST_SKIP;
                end
            endcase
        end else if (scl_fall && ackph_q) begin
            // End of the ninth clock: release the line
            sda_oe_o <= 1'b0;
            ackph_q  <= 1'b0;
            bit_q    <= 4'h0;
        end
    end

    // ------------------------------------------------------------------
    // Self-timed write cycle and commit of the page buffer
    // ------------------------------------------------------------------
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            busy_q   <= 1'b0;
            cnt_q    <= {`WR_CNT_W{1'b0}};
            commit_q <= 1'b0;
            cidx_q   <= 4'h0;
            lock_q   <= 1'b0;
        end else if (!busy_q) begin
            if (stop_p && wpend_q) begin
                busy_q   <= 1'b1;
                cnt_q    <= WR_LOAD;
                commit_q <= 1'b1;
                cidx_q   <= 4'h0;
                lock_q   <= lock_q | lockpend_q;
            end
        end else begin
            cnt_q <= cnt_q - {{(`WR_CNT_W-1){1'b0}}, 1'b1};
            if (cnt_q == {{(`WR_CNT_W-1){1'b0}}, 1'b1}) begin
                busy_q <= 1'b0;
            end
            if (commit_q) begin
                cidx_q <= cidx_q + `BIT_ONE;
                if (cidx_q == `PAGE_LAST) begin
                    commit_q <= 1'b0;
                end
            end
        end
    end

    wire commit_on = commit_q && mask_q[cidx_q];
    wire mem_we    = commit_on && (area_q == `AR_MEM);
    wire sec_we    = commit_on && (area_q == `AR_SEC) && !lock_q;

    // ------------------------------------------------------------------
    // Page buffer and security sector storage, one entry per byte
    // ------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi = gi + 1) begin : g_entry
            always @(posedge clock_i or negedge nrst_i) begin
                if (!nrst_i) begin
                    buf_q[gi] <= 8'h00;
                end else if (buf_we && (waddr_q[3:0] == gi)) begin
                    buf_q[gi] <= shift_q;
                end
            end

            always @(posedge clock_i or negedge nrst_i) begin
                if (!nrst_i) begin
                    sec_q[gi] <= 8'hFF;
                end else if (sec_we && (cidx_q == gi)) begin
                    sec_q[gi] <= buf_q[gi];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Data memory
    // ------------------------------------------------------------------
    wire [7:0] mem_rdata;

    byte_store u_store (
        .clock_i (clock_i),
        .nrst_i  (nrst_i),
        .we_i    (mem_we),
        .waddr_i ({page_q, waddr_q[7:4], cidx_q}),
        .wdata_i (buf_q[cidx_q]),
        .raddr_i (peek_addr_i[`MEM_AW-1:0]),
        .rdata_o (mem_rdata)
    );

    // ------------------------------------------------------------------
    // Registered status and inspection outputs
    // ------------------------------------------------------------------
    reg        peek_sec_q;
    reg  [7:0] sec_rd_q;

    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            busy_o      <= 1'b0;
            locked_o    <= 1'b0;
            peek_sec_q  <= 1'b0;
            sec_rd_q    <= 8'h00;
            peek_data_o <= 8'h00;
        end else begin
            busy_o      <= busy_q;
            locked_o    <= lock_q;
            peek_sec_q  <= peek_addr_i[`MEM_AW];
            sec_rd_q    <= sec_q[peek_addr_i[3:0]];
            peek_data_o <= peek_sec_q ? sec_rd_q : mem_rdata;
        end
    end

endmodule
`default_nettype wire

// *** sim/eeprom_target_asserts.sv ***
// Port-level assertions for the two-wire EEPROM target
`timescale 1ns/1ps
`default_nettype none
module eeprom_target_asserts #(
    parameter int WR_CYCLES = 625000
) (
    // Clock and reset
    input wire logic        clock_i,
    input wire logic        nrst_i,
    // Pins
    input wire logic        scl_i,
    input wire logic        sda_i,
    input wire logic        sda_o,
    input wire logic        sda_oe_o,
    input wire logic        wp_i,
    // Status and inspection
    input wire logic        busy_o,
    input wire logic        standby_o,
    input wire logic        locked_o,
    input wire logic [11:0] peek_addr_i,
    input wire logic [7:0]  peek_data_o
);
    // ------------------------------------
    // Helpers
    // ------------------------------------
    logic [19:0] blen_q;

    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!nrst_i);

    // Length of the running busy interval
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i)
            blen_q <= 20'h0;
        else
            blen_q <= busy_o ? blen_q + 20'h1 : 20'h0;
    end

    // Stop on the raw pins, and a held acknowledge
    sequence raw_stop;
        scl_i && $rose(sda_i);
    endsequence
    sequence ack_hold;
        sda_oe_o [*8];
    endsequence

    // ------------------------------------
    // Checks
    // ------------------------------------
    chk_ack_low: assert property (sda_oe_o |-> !sda_o)
        else $error("ack drives a high level");
    chk_ack_width: assert property ($rose(sda_oe_o) |-> ack_hold)
        else $error("ack pulse too short");
    chk_ack_edge: assert property ($changed(sda_oe_o) |-> !$past(scl_i))
        else $error("data drive changed with clock high");
    chk_busy_quiet: assert property (busy_o |-> !sda_oe_o)
        else $error("answer while busy");
    chk_busy_length: assert property ($fell(busy_o) |->
        blen_q >= WR_CYCLES - 1 && blen_q <= WR_CYCLES + 20)
        else $error("write cycle length wrong");
    chk_stop_settle: assert property (raw_stop |->
        ##[1:8] (standby_o || busy_o))
        else $error("no standby or write cycle after stop");
    chk_idle_standby: assert property (
        $fell(busy_o) |-> ##[0:2] standby_o)
        else $error("no standby after write cycle");
    chk_lock_sticky: assert property ($past(locked_o) |-> locked_o)
        else $error("lock cleared");
    chk_peek_steady: assert property (
        (!busy_o && $stable(peek_addr_i)) [*3] |=> $stable(peek_data_o))
        else $error("contents changed while idle");
endmodule

bind eeprom_target eeprom_target_asserts #(.WR_CYCLES(WR_CYCLES)) u_chk (
    .clock_i(clock_i), .nrst_i(nrst_i), .scl_i(scl_i), .sda_i(sda_i),
    .sda_o(sda_o), .sda_oe_o(sda_oe_o), .wp_i(wp_i), .busy_o(busy_o),
    .standby_o(standby_o), .locked_o(locked_o),
    .peek_addr_i(peek_addr_i), .peek_data_o(peek_data_o)
);
`default_nettype wire

// *** sim/bus_master_model.sv ***
// Behavioural two-wire bus master with open-drain data drive
`timescale 1ns/1ps
`default_nettype none
module bus_master_model (
    // Bus lines
    input  wire logic sda_i,
    output var logic  scl_o,
    output var logic  sda_low_o
);
    localparam real QTR = 31.25; // Quarter of the 125 ns bit period

    // Idle bus: clock stands high, data released
    initial begin
        scl_o = 1'h1;
        sda_low_o = 1'h0;
    end

    // Start or repeated start: data falls while clock is high
    task automatic start_c;
        sda_low_o = 1'h0;
        #(2*QTR) scl_o = 1'h1;
        #QTR sda_low_o = 1'h1;
        #QTR scl_o = 1'h0;
        #QTR;
    endtask

    // Stop: data rises while clock is high, bus left idle
    task automatic stop_c;
        sda_low_o = 1'h1;
        #QTR scl_o = 1'h1;
        #QTR sda_low_o = 1'h0;
        #(2*QTR);
    endtask

    // Eight bits MSB first, data moved only with clock low, then ack
    task automatic send_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            #QTR sda_low_o = ~b[i];
            #QTR scl_o = 1'h1;
            #(2*QTR) scl_o = 1'h0;
        end
        #QTR sda_low_o = 1'h0;
        #QTR scl_o = 1'h1;
        #QTR ack = ~sda_i;
        #QTR scl_o = 1'h0;
    endtask

    // Bus recovery: nine clocks with data released
    task automatic recover;
        sda_low_o = 1'h0;
        repeat (9) begin
            #(2*QTR) scl_o = 1'h0;
            #(2*QTR) scl_o = 1'h1;
        end
    endtask
endmodule
`default_nettype wire

// *** sim/tb_eeprom_target.sv ***
// Self-checking bench for the two-wire EEPROM target write path
`timescale 1ns/1ps
`default_nettype none
module tb_eeprom_target;
    localparam int WRC = 300; // Shortened write cycle
    logic        clock_i = 1'h0;
    logic        nrst_i = 1'h0;
    logic        wp_i = 1'h0;
    logic [11:0] peek_addr_i = 12'h800;
    wire         scl_i;
    wire         sda_low;
    wire         sda_o;
    wire         sda_oe_o;
    wire         busy_o;
    wire         standby_o;
    wire         locked_o;
    wire  [7:0]  peek_data_o;
    wire         sda_i = ~sda_low & (sda_oe_o ? sda_o : 1'h1); // Pulled-up
    int          fail_count = 0;
    int          comparisons = 0;
    // Rows: expected ack, then device word
    logic [8:0]  rows [8] = '{9'h1A0, 9'h1A1, 9'h1AE, 9'h1B1,
                              9'h050, 9'h0C0, 9'h0E0, 9'h01A};

    eeprom_target #(.WR_CYCLES(WRC)) u_dut (
        .clock_i(clock_i), .nrst_i(nrst_i), .scl_i(scl_i), .sda_i(sda_i),
        .sda_o(sda_o), .sda_oe_o(sda_oe_o), .wp_i(wp_i), .busy_o(busy_o),
        .standby_o(standby_o), .locked_o(locked_o),
        .peek_addr_i(peek_addr_i), .peek_data_o(peek_data_o));
    bus_master_model u_mst (.sda_i(sda_i), .scl_o(scl_i), .sda_low_o(sda_low));

    // 125 MHz clock
    initial begin
        forever #4 clock_i = ~clock_i;
    end

    // ------------------------------------
    // Tasks
    // ------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic send(input logic [7:0] b, input logic e);
        logic a;
        u_mst.send_byte(b, a);
        check(a, e);
    endtask

    task automatic write3(input logic [7:0] d0, d1, d2, input logic [2:0] e);
        u_mst.start_c();
        send(d0, e[2]);
        send(d1, e[1]);
        send(d2, e[0]);
        u_mst.stop_c();
        @(negedge clock_i);
    endtask

    task automatic wait_idle;
        int n;
        @(negedge clock_i);
        check(busy_o, 1'h1);
        for (n = 0; n < 2000 && busy_o !== 1'h0; n++)
            @(negedge clock_i);
        if (n == 2000) begin
            fail_count++;
            finish_test();
        end
        repeat (3) @(negedge clock_i);
    endtask

    task automatic peek(input logic [11:0] ad, input logic [7:0] e);
        @(negedge clock_i);
        peek_addr_i = ad;
        repeat (3) @(negedge clock_i);
        check(peek_data_o, e);
    endtask

    // ------------------------------------
    // Main sequence
    // ------------------------------------
    initial begin
        repeat (5) @(negedge clock_i);
        check({standby_o, busy_o, locked_o, sda_oe_o}, 4'h8);
        check(peek_data_o, 8'h00);
        nrst_i = 1'h1;
        repeat (5) @(negedge clock_i);
        for (int r = 0; r < 8; r++) begin
            u_mst.start_c();
            send(rows[r][7:0], rows[r][8]);
            u_mst.stop_c();
            repeat (2) @(negedge clock_i);
            check({standby_o, busy_o}, 2'h2);
        end
        // Byte write, then polling during and after the write cycle
        write3(8'hA6, 8'h45, 8'h5A, 3'h7);
        u_mst.start_c();
        send(8'hA0, 1'h0);
        u_mst.stop_c();
        wait_idle();
        check(standby_o, 1'h1);
        u_mst.start_c();
        send(8'hA0, 1'h1);
        u_mst.stop_c();
        peek(12'h345, 8'h5A);
        // Page write of seventeen bytes from offset E wraps in the page
        u_mst.start_c();
        send(8'hA2, 1'h1);
        send(8'h1E, 1'h1);
        for (int i = 0; i < 17; i++)
            send(8'h10 + 8'(i), 1'h1);
        u_mst.stop_c();
        wait_idle();
        for (int j = 0; j < 16; j++)
            peek({8'h11, 4'(j)},
                 (j == 14) ? 8'h20 : 8'h10 + 8'((j + 2) & 15));
        // Write-protect: acked but not stored, no write cycle
        wp_i = 1'h1;
        write3(8'hA6, 8'h45, 8'h99, 3'h7);
        check(busy_o, 1'h0);
        wp_i = 1'h0;
        peek(12'h345, 8'h5A);
        // Sector, identifier and lock
        write3(8'hB0, 8'h33, 8'hC3, 3'h7);
        wait_idle();
        peek(12'h803, 8'hC3);
        peek(12'h804, 8'hFF);
        write3(8'hB0, 8'h80, 8'h55, 3'h6);
        write3(8'hB0, 8'h40, 8'hFD, 3'h7);
        check({locked_o, busy_o}, 2'h0);
        write3(8'hB0, 8'hC0, 8'h02, 3'h7);
        wait_idle();
        check(locked_o, 1'h1);
        write3(8'hB0, 8'h03, 8'h11, 3'h6);
        write3(8'hB0, 8'h40, 8'h02, 3'h6);
        peek(12'h803, 8'hC3);
        // Repeated start mid-command drops the buffered byte
        u_mst.start_c();
        send(8'hA0, 1'h1);
        send(8'h10, 1'h1);
        send(8'h77, 1'h1);
        u_mst.start_c();
        u_mst.stop_c();
        @(negedge clock_i);
        check(busy_o, 1'h0);
        // Reset in mid-frame, bus recovery, then a fresh write
        u_mst.start_c();
        send(8'hA0, 1'h1);
        repeat (10) @(negedge clock_i);
        nrst_i = 1'h0;
        repeat (2) @(negedge clock_i);
        check({standby_o, locked_o}, 2'h2);
        nrst_i = 1'h1;
        repeat (5) @(negedge clock_i);
        u_mst.recover();
        check(sda_i, 1'h1);
        write3(8'hA6, 8'h45, 8'h3C, 3'h7);
        wait_idle();
        peek(12'h345, 8'h3C);
        finish_test();
    end
endmodule
`default_nettype wire
